// >>> pkg/ldc_drv_if.sv
// interface: one driver's settings from register bank to target calculator
`timescale 1ns/1ps
interface ldc_drv_if;
    logic strength_sel;
    logic [2:0] edge_rate;
    logic [3:0] coarse_code;
    logic [4:0] fine_code;
    logic [31:0] peak_target;
    modport bank (output strength_sel, edge_rate, coarse_code, fine_code,
                  input peak_target);
    modport calc (input strength_sel, edge_rate, coarse_code, fine_code,
                  output peak_target);
endinterface : ldc_drv_if

// >>> pkg/ldc_pkg.sv
// package: register map, field layout, reset values and scale constants
package ldc_pkg;
    // register indices on the host register port (one 16-bit word each)
    localparam logic [7:0] LDC_THIRD_DRV_ADDR = 8'h22;
    localparam logic [7:0] LDC_FIRST_DRV_ADDR = 8'h23;
    localparam logic [7:0] LDC_SECOND_DRV_ADDR = 8'h24;
    localparam logic [7:0] LDC_FINE_ADJ_ADDR = 8'h25;
    // field positions inside a driver register
    localparam int LDC_STRENGTH_BIT = 13;
    localparam int LDC_RSV_ONE_BIT = 12;
    localparam int LDC_EDGE_LSB = 4;
    localparam int LDC_EDGE_MSB = 6;
    localparam int LDC_COARSE_LSB = 0;
    localparam int LDC_COARSE_MSB = 3;
    // fine-adjust register fields
    localparam int LDC_FINE1_LSB = 0;
    localparam int LDC_FINE2_LSB = 6;
    localparam int LDC_FINE3_LSB = 11;
    localparam int LDC_FINE_W = 5;
    // reset values: drivers at full strength, reserved bit 12 set, rest zero; all three fine codes 12
    localparam logic [15:0] LDC_DRV_RESET = 16'h3000;
    localparam logic [15:0] LDC_FINE_RESET = 16'h630C;
    // writable mask of a driver register: bits 13..0 minus reserved 11..7
    localparam logic [15:0] LDC_DRV_WMASK = 16'h307F;
    localparam logic [15:0] LDC_FINE_WMASK = 16'hFFDF;
    // scale in tenths: 1 + 9 * sel  (0.1 + 0.9 * sel)
    localparam logic [3:0] LDC_SCALE_BASE = 4'h1;
    localparam logic [3:0] LDC_SCALE_STEP = 4'h9;
    // coarse term in tenths of mA: 503 + 198 * code
    localparam logic [11:0] LDC_COARSE_BASE = 12'h1F7;
    localparam logic [11:0] LDC_COARSE_STEP = 12'h0C6;
    // fine term in thousandths: 740 + 22 * code
    localparam logic [11:0] LDC_FINE_BASE = 12'h2E4;
    localparam logic [11:0] LDC_FINE_STEP = 12'h016;
endpackage : ldc_pkg

// >>> rtl/ldc_led_drive_cfg.sv
// module: emitter driver current configuration register bank
`timescale 1ns/1ps
module ldc_led_drive_cfg
    import ldc_pkg::*;
(
    input wire logic i_ref_clk, // 200 MHz system clock
    input wire logic i_sys_rst, // async reset, active high
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_reg_rd, // register read strobe
    input wire logic [7:0] i_reg_addr, // register address
    input wire logic [15:0] i_reg_wdata, // write data
    output logic [15:0] o_reg_rdata, // read data, one cycle after read
    output logic [2:0] o_drv_low_power, // per driver: 10% strength
    output logic [2:0] o_first_driver_edge_rate, // first edge rate
    output logic [2:0] o_second_driver_edge_rate, // second edge rate
    output logic [2:0] o_third_driver_edge_rate, // third edge rate
    output logic [3:0] o_first_driver_coarse_code, // first coarse
    output logic [3:0] o_second_driver_coarse_code, // second coarse
    output logic [3:0] o_third_driver_coarse_code, // third coarse
    output logic [31:0] o_first_peak_target, // 1e-5 mA units
    output logic [31:0] o_second_peak_target, // 1e-5 mA units
    output logic [31:0] o_third_peak_target // 1e-5 mA units
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [15:0] third_driver_drive_config_reg;
    logic [15:0] first_driver_drive_config_reg;
    logic [15:0] second_driver_drive_config_reg;
    logic [15:0] fine_adjust_reg;

    // ------------------------------------------------------------
    // decode helpers shared by the three drivers
    // ------------------------------------------------------------
    // bits 15:14 and 11:7 ignore writes and keep their reset value;
    // bit 12 is stored, so software has to keep writing it as 1
    function automatic logic [15:0] drv_merge(input logic [15:0] d);
        drv_merge = (d & LDC_DRV_WMASK) | (LDC_DRV_RESET & ~LDC_DRV_WMASK);
    endfunction : drv_merge

    // one strobe and one address compare per register
    function automatic logic addr_hit(input logic strobe,
                                      input logic [7:0] addr,
                                      input logic [7:0] match);
        addr_hit = strobe && (addr == match);
    endfunction : addr_hit

    function automatic logic strength_of(input logic [15:0] d);
        strength_of = d[LDC_STRENGTH_BIT];
    endfunction : strength_of

    function automatic logic [2:0] edge_of(input logic [15:0] d);
        edge_of = d[LDC_EDGE_MSB:LDC_EDGE_LSB];
    endfunction : edge_of

    function automatic logic [3:0] coarse_of(input logic [15:0] d);
        coarse_of = d[LDC_COARSE_MSB:LDC_COARSE_LSB];
    endfunction : coarse_of

    function automatic logic [4:0] fine_of(input logic [15:0] f,
                                           input int lsb);
        fine_of = f[lsb +: LDC_FINE_W];
    endfunction : fine_of

    function automatic logic [15:0] read_word(input logic [7:0] addr,
                                              input logic [15:0] third,
                                              input logic [15:0] first,
                                              input logic [15:0] second,
                                              input logic [15:0] fine);
        case (addr)
            LDC_THIRD_DRV_ADDR: read_word = third;
            LDC_FIRST_DRV_ADDR: read_word = first;
            LDC_SECOND_DRV_ADDR: read_word = second;
            LDC_FINE_ADJ_ADDR: read_word = fine;
            default: read_word = 16'h0000;
        endcase
    endfunction : read_word

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            third_driver_drive_config_reg <= LDC_DRV_RESET;
        end else if (addr_hit(i_reg_wr, i_reg_addr, LDC_THIRD_DRV_ADDR)) begin
            third_driver_drive_config_reg <= drv_merge(i_reg_wdata);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            first_driver_drive_config_reg <= LDC_DRV_RESET;
        end else if (addr_hit(i_reg_wr, i_reg_addr, LDC_FIRST_DRV_ADDR)) begin
            first_driver_drive_config_reg <= drv_merge(i_reg_wdata);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            second_driver_drive_config_reg <= LDC_DRV_RESET;
        end else if (addr_hit(i_reg_wr, i_reg_addr, LDC_SECOND_DRV_ADDR)) begin
            second_driver_drive_config_reg <= drv_merge(i_reg_wdata);
        end
    end

    // reserved bit 5 of the fine register held at zero
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fine_adjust_reg <= LDC_FINE_RESET;
        end else if (addr_hit(i_reg_wr, i_reg_addr, LDC_FINE_ADJ_ADDR)) begin
            fine_adjust_reg <= i_reg_wdata & LDC_FINE_WMASK;
        end
    end

    // ------------------------------------------------------------
    // read port: unmapped addresses read zero
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            o_reg_rdata <= read_word(i_reg_addr,
                                     third_driver_drive_config_reg,
                                     first_driver_drive_config_reg,
                                     second_driver_drive_config_reg,
                                     fine_adjust_reg);
        end
    end

    // ------------------------------------------------------------
    // field decode and target calculation
    // ------------------------------------------------------------
    ldc_drv_if first_if ();
    ldc_drv_if second_if ();
    ldc_drv_if third_if ();

    assign first_if.strength_sel =
        strength_of(first_driver_drive_config_reg);
    assign first_if.edge_rate =
        edge_of(first_driver_drive_config_reg);
    assign first_if.coarse_code =
        coarse_of(first_driver_drive_config_reg);
    assign first_if.fine_code =
        fine_of(fine_adjust_reg, LDC_FINE1_LSB);
    assign second_if.strength_sel =
        strength_of(second_driver_drive_config_reg);
    assign second_if.edge_rate =
        edge_of(second_driver_drive_config_reg);
    assign second_if.coarse_code =
        coarse_of(second_driver_drive_config_reg);
    assign second_if.fine_code =
        fine_of(fine_adjust_reg, LDC_FINE2_LSB);
    assign third_if.strength_sel =
        strength_of(third_driver_drive_config_reg);
    assign third_if.edge_rate =
        edge_of(third_driver_drive_config_reg);
    assign third_if.coarse_code =
        coarse_of(third_driver_drive_config_reg);
    assign third_if.fine_code =
        fine_of(fine_adjust_reg, LDC_FINE3_LSB);

    ldc_peak_calc u_first_calc (.drv(first_if));
    ldc_peak_calc u_second_calc (.drv(second_if));
    ldc_peak_calc u_third_calc (.drv(third_if));

    // ------------------------------------------------------------
    // registered outputs, one cycle behind the register contents
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_drv_low_power <= 3'h0;
        end else begin
            o_drv_low_power <= {~third_if.strength_sel,
                                ~second_if.strength_sel,
                                ~first_if.strength_sel};
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_first_driver_edge_rate <= 3'h0;
            o_second_driver_edge_rate <= 3'h0;
            o_third_driver_edge_rate <= 3'h0;
        end else begin
            o_first_driver_edge_rate <= first_if.edge_rate;
            o_second_driver_edge_rate <= second_if.edge_rate;
            o_third_driver_edge_rate <= third_if.edge_rate;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_first_driver_coarse_code <= 4'h0;
            o_second_driver_coarse_code <= 4'h0;
            o_third_driver_coarse_code <= 4'h0;
        end else begin
            o_first_driver_coarse_code <= first_if.coarse_code;
            o_second_driver_coarse_code <= second_if.coarse_code;
            o_third_driver_coarse_code <= third_if.coarse_code;
        end
    end

    // targets reset to zero; real value appears one edge after release
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_first_peak_target <= 32'h0000_0000;
            o_second_peak_target <= 32'h0000_0000;
            o_third_peak_target <= 32'h0000_0000;
        end else begin
            o_first_peak_target <= first_if.peak_target;
            o_second_peak_target <= second_if.peak_target;
            o_third_peak_target <= third_if.peak_target;
        end
    end
endmodule : ldc_led_drive_cfg

// >>> rtl/ldc_peak_calc.sv
// module: peak current target of one driver in 1e-5 mA units
`timescale 1ns/1ps
module ldc_peak_calc
    import ldc_pkg::*;
(
    ldc_drv_if.calc drv // settings in, target out
);
    logic [11:0] coarse_t;
    logic [11:0] fine_t;
    logic [3:0] scale_t;
    logic [23:0] cf;
    always_comb begin
        coarse_t = LDC_COARSE_BASE
                 + 12'(LDC_COARSE_STEP * 12'(drv.coarse_code));
        fine_t = LDC_FINE_BASE
               + 12'(LDC_FINE_STEP * 12'(drv.fine_code));
        scale_t = drv.strength_sel ? LDC_SCALE_BASE + LDC_SCALE_STEP
                                   : LDC_SCALE_BASE;
        cf = 24'(coarse_t) * 24'(fine_t);
        drv.peak_target = 32'(cf) * 32'(scale_t);
    end
endmodule : ldc_peak_calc

// >>> tb/ldc_led_drive_cfg_props.sv
// checker: port-level assertions for the drive current register bank
`timescale 1ns/1ps
module ldc_led_drive_cfg_props
    import ldc_pkg::*;
(
    input wire logic i_ref_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_reg_wr, // write
    input wire logic i_reg_rd, // read
    input wire logic [7:0] i_reg_addr, // address
    input wire logic [15:0] i_reg_wdata, // wdata
    input wire logic [15:0] o_reg_rdata, // rdata
    input wire logic [2:0] o_drv_low_power, // low power
    input wire logic [2:0] o_first_driver_edge_rate, // edge 1
    input wire logic [2:0] o_third_driver_edge_rate, // edge 3
    input wire logic [3:0] o_first_driver_coarse_code, // coarse 1
    input wire logic [3:0] o_third_driver_coarse_code, // coarse 3
    input wire logic [31:0] o_first_peak_target, // peak 1
    input wire logic [31:0] o_third_peak_target // peak 3
);
    // -------------------------------------------------------------
    // shadow of write data and fine register
    // -------------------------------------------------------------
    logic [15:0] wd1_reg, wd2_reg, fine_reg, fine_d_reg;
    logic up_reg;
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wd1_reg <= 16'h0000;
            wd2_reg <= 16'h0000;
        end else begin
            wd1_reg <= i_reg_wdata;
            wd2_reg <= wd1_reg;
        end
    end
    // derived outputs lag the register by one edge, so the shadow does too
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fine_reg <= LDC_FINE_RESET;
            fine_d_reg <= LDC_FINE_RESET;
            up_reg <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == LDC_FINE_ADJ_ADDR) begin
                fine_reg <= i_reg_wdata;
            end
            fine_d_reg <= fine_reg;
            up_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    chk_first_fields: assert property (
        i_reg_wr && i_reg_addr == LDC_FIRST_DRV_ADDR |-> ##2
        o_drv_low_power[0] == !wd2_reg[13] && {o_first_driver_edge_rate,
        o_first_driver_coarse_code} == wd2_reg[6:0])
        else $error("first driver fields do not follow write");
    chk_third_fields: assert property (
        i_reg_wr && i_reg_addr == LDC_THIRD_DRV_ADDR |-> ##2
        o_drv_low_power[2] == !wd2_reg[13] && {o_third_driver_edge_rate,
        o_third_driver_coarse_code} == wd2_reg[6:0])
        else $error("third driver fields do not follow write");
    chk_second_sel: assert property (
        i_reg_wr && i_reg_addr == LDC_SECOND_DRV_ADDR |-> ##2
        o_drv_low_power[1] == !wd2_reg[13])
        else $error("second driver low power wrong");
    chk_rsv_high: assert property (
        i_reg_rd && i_reg_addr inside {8'h22, 8'h23, 8'h24} |=>
        o_reg_rdata[15:14] == 2'h0)
        else $error("reserved high bits not zero");
    chk_rsv_mid: assert property (
        i_reg_rd && i_reg_addr inside {8'h22, 8'h23, 8'h24} |=>
        o_reg_rdata[12:7] == 6'h20)
        else $error("reserved middle bits wrong");
    chk_write_read_back: assert property (
        i_reg_wr && i_reg_addr == LDC_FIRST_DRV_ADDR ##1 i_reg_rd &&
        !i_reg_wr && i_reg_addr == LDC_FIRST_DRV_ADDR |=>
        o_reg_rdata[13] == wd2_reg[13] && o_reg_rdata[6:0] == wd2_reg[6:0])
        else $error("first driver read back wrong");
    chk_peak_first: assert property (
        up_reg |-> o_first_peak_target == (LDC_COARSE_BASE +
        LDC_COARSE_STEP * o_first_driver_coarse_code) * (LDC_FINE_BASE +
        LDC_FINE_STEP * fine_d_reg[4:0]) * (o_drv_low_power[0] ? 4'h1 : 4'hA))
        else $error("first peak target wrong");
    chk_peak_third: assert property (
        up_reg |-> o_third_peak_target == (LDC_COARSE_BASE +
        LDC_COARSE_STEP * o_third_driver_coarse_code) * (LDC_FINE_BASE +
        LDC_FINE_STEP * fine_d_reg[15:11]) * (o_drv_low_power[2] ? 4'h1 : 4'hA))
        else $error("third peak target wrong");
endmodule : ldc_led_drive_cfg_props

bind ldc_led_drive_cfg ldc_led_drive_cfg_props u_props (.i_ref_clk,
    .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_drv_low_power, .o_first_driver_edge_rate,
    .o_third_driver_edge_rate, .o_first_driver_coarse_code,
    .o_third_driver_coarse_code, .o_first_peak_target,
    .o_third_peak_target);

// >>> tb/testbench.sv
// testbench: corner and random register traffic with output checks
`timescale 1ns/1ps
module testbench;
    logic i_ref_clk, i_sys_rst, i_reg_wr, i_reg_rd;
    logic [7:0] i_reg_addr;
    logic [15:0] i_reg_wdata, o_reg_rdata;
    logic [2:0] o_drv_low_power, o_first_driver_edge_rate;
    logic [2:0] o_second_driver_edge_rate, o_third_driver_edge_rate;
    logic [3:0] o_first_driver_coarse_code, o_second_driver_coarse_code;
    logic [3:0] o_third_driver_coarse_code;
    logic [31:0] o_first_peak_target, o_second_peak_target;
    logic [31:0] o_third_peak_target;
    logic [15:0] m [0:3];
    int n_errors = 0;
    int num_checks = 0;
    ldc_led_drive_cfg dut (.i_ref_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd,
        .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_drv_low_power,
        .o_first_driver_edge_rate, .o_second_driver_edge_rate,
        .o_third_driver_edge_rate, .o_first_driver_coarse_code,
        .o_second_driver_coarse_code, .o_third_driver_coarse_code,
        .o_first_peak_target, .o_second_peak_target, .o_third_peak_target);
    // ---------------------------------------------------------------
    // expectations and bus cycles
    // ---------------------------------------------------------------
    function automatic logic [39:0] drv_exp(logic [15:0] d, logic [4:0] f);
        drv_exp = {~d[13], d[6:0], (32'h1F7 + 32'hC6 * d[3:0]) *
            (32'h2E4 + 32'h16 * f) * (d[13] ? 32'hA : 32'h1)};
    endfunction : drv_exp
    // software keeps reserved driver bits at 0 and bit 12 at 1
    function automatic logic [15:0] legal(logic [7:0] a, logic [15:0] d);
        legal = d;
        if (a inside {8'h22, 8'h23, 8'h24}) begin
            legal = (d & 16'h207F) | 16'h1000;
        end
    endfunction : legal
    task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic op(logic w, logic r, logic [7:0] a, logic [15:0] d);
        @(posedge i_ref_clk);
        i_reg_wr <= w;
        i_reg_rd <= r;
        i_reg_addr <= a;
        i_reg_wdata <= d;
    endtask : op
    // write then read back at once, so a stale register shows up
    task automatic wr_rd(logic w, logic [7:0] a, logic [15:0] d);
        logic [7:0] k;
        logic [15:0] dd;
        logic [39:0] seen;
        logic [39:0] want;
        k = a - 8'h22;
        dd = legal(a, d);
        if (w) op(1'b1, 1'b0, a, dd);
        op(1'b0, 1'b1, a, 16'h0000);
        op(1'b0, 1'b0, 8'h00, 16'h0000);
        if (w && k < 3) m[k] = {2'h0, dd[13], 1'h1, 5'h00, dd[6:0]};
        else if (w && k == 3) m[k] = dd & 16'hFFDF;
        #1;
        want = {24'h0, k < 4 ? m[k] : 16'h0};
        check("rdata", {24'h0, o_reg_rdata}, want);
        seen = {o_drv_low_power[0], o_first_driver_edge_rate,
                o_first_driver_coarse_code, o_first_peak_target};
        want = drv_exp(m[1], m[3][4:0]);
        check("first", seen, want);
        seen = {o_drv_low_power[1], o_second_driver_edge_rate,
                o_second_driver_coarse_code, o_second_peak_target};
        want = drv_exp(m[2], m[3][10:6]);
        check("second", seen, want);
        seen = {o_drv_low_power[2], o_third_driver_edge_rate,
                o_third_driver_coarse_code, o_third_peak_target};
        want = drv_exp(m[0], m[3][15:11]);
        check("third", seen, want);
    endtask : wr_rd
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        n_errors++;
        conclude();
    end
    initial begin
        {i_sys_rst, i_reg_wr, i_reg_rd} = 3'h4;
        i_reg_addr = 8'h00;
        i_reg_wdata = 16'h0000;
        m = '{16'h3000, 16'h3000, 16'h3000, 16'h630C};
        void'($urandom(32'hA282));
        repeat (10) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        // reset values first, then extreme codes, then random traffic
        for (int a = 8'h21; a < 8'h27; a++) wr_rd(1'b0, 8'(a), 16'h0000);
        for (int a = 8'h21; a < 8'h27; a++) begin
            wr_rd(1'b1, 8'(a), 16'h0000);
            wr_rd(1'b1, 8'(a), 16'hFFFF);
        end
        repeat (60) wr_rd(1'b1, 8'h21 + 8'($urandom_range(5)), 16'($urandom));
        conclude();
    end
endmodule : testbench
